// ### core/mlf_pkg.sv
package mlf_pkg;
    // timing
    localparam int CLK_FREQ_HZ   = 20_000_000;
    localparam int MS_PER_S      = 1000;
    localparam int CYC_PER_MS    = CLK_FREQ_HZ / MS_PER_S;
    localparam int NOMTR_TIME_US = 100;
    localparam int NOMTR_CYCLES  = NOMTR_TIME_US * (CLK_FREQ_HZ / 1_000_000);
    localparam int DW            = 16;

    // register byte addresses (fault settings word sits at index * 4)
    localparam logic [11:0] FS2_IDX    = 12'h092;
    localparam logic [11:0] ADR_FS2    = 12'h248;
    localparam logic [11:0] ADR_LCTL   = 12'h000;
    localparam logic [11:0] ADR_KBASE  = 12'h004;
    localparam logic [11:0] ADR_MAXSPD = 12'h008;
    localparam logic [11:0] ADR_STS    = 12'h00C;
    localparam logic [11:0] ADR_MSK    = 12'h010;
    localparam logic [11:0] ADR_STATE  = 12'h014;
    localparam logic [31:0] FS2_RST    = 32'h00000000;

    // fault settings field positions
    localparam int SAT_EN_BIT  = 0;
    localparam int IPD_EN_BIT  = 1;
    localparam int NOMTR_LSB   = 19;
    localparam int BEMF_LSB    = 22;
    localparam int SPD_LSB     = 25;
    localparam int L3_EN_BIT   = 28;
    localparam int L2_EN_BIT   = 29;
    localparam int L1_EN_BIT   = 30;

    // lock control fields
    localparam int MODE_LSB    = 0;
    localparam int RETRY_LSB   = 4;
    localparam int RLIM_LSB    = 8;
    localparam int FCLR_BIT    = 16;

    // status bits
    localparam int ST_SPD  = 0;
    localparam int ST_BEMF = 1;
    localparam int ST_NOM  = 2;
    localparam int ST_IPD  = 3;
    localparam int ST_LOCK = 4;
    localparam int ST_SAT  = 5;

    localparam logic [47:0] PM_SCALE = 48'h0000000003E8; // per-mille base

    typedef enum logic [1:0] {
        MLF_IDLE, MLF_LATCHED, MLF_RETRY, MLF_REPORT
    } mlf_lock_type;

    // speed threshold, per-mille of max speed
    function automatic logic [47:0] mlf_spd_pm(input logic [2:0] c);
        return 48'(13'h514 + 13'(c) * 13'h064);
    endfunction

    // back-emf threshold, per-mille of expected back-emf
    function automatic logic [47:0] mlf_bemf_pm(input logic [2:0] c);
        case (c)
            3'h6:    return 48'h2A3;
            3'h7:    return 48'h2BC;
            default: return 48'(10'h190 + 10'(c) * 10'h032);
        endcase
    endfunction

    // no-motor threshold, per-mille of base_cur
    function automatic logic [47:0] mlf_nom_pm(input logic [2:0] c);
        case (c)
            3'h5:    return 48'h04B;
            3'h6:    return 48'h064;
            3'h7:    return 48'h0C8;
            default: return 48'(8'h0A + 8'(c) * 8'h0A);
        endcase
    endfunction

    // retry interval in milliseconds
    function automatic logic [31:0] mlf_retry_ms(input logic [3:0] c);
        case (c)
            4'h0:    return 32'h12C;
            4'h1:    return 32'h1F4;
            default: return 32'(c - 4'h1) * 32'h3E8;
        endcase
    endfunction
endpackage

// ### core/mlf_det_if.sv
`timescale 1ns/1ps
interface mlf_det_if;
    logic [31:0]             fs2;
    logic [mlf_pkg::DW-1:0]  kconst;
    logic [mlf_pkg::DW-1:0]  base_cur;
    logic [mlf_pkg::DW-1:0]  max_spd;
    logic                    f_spd;
    logic                    f_bemf;
    logic                    f_nom;
    logic                    f_ipd;
    logic                    f_cur_sat;
    logic                    f_spd_sat;

    modport ctl (output fs2, kconst, base_cur, max_spd,
                 input f_spd, f_bemf, f_nom, f_ipd, f_cur_sat, f_spd_sat);
    modport det (input fs2, kconst, base_cur, max_spd,
                 output f_spd, f_bemf, f_nom, f_ipd, f_cur_sat, f_spd_sat);
endinterface

// ### core/mlf_det.sv
`timescale 1ns/1ps
module mlf_det #(
    parameter int NOMTR_CYC = mlf_pkg::NOMTR_CYCLES
) (
    input  wire logic                   i_clk_sys,
    input  wire logic                   i_nrst,
    mlf_det_if.det                      cfg,
    input  wire logic [mlf_pkg::DW-1:0] i_speed,
    input  wire logic [mlf_pkg::DW-1:0] i_bemf,
    input  wire logic [mlf_pkg::DW-1:0] i_current,
    input  wire logic                   i_ipd_freq_err,
    input  wire logic                   i_cur_sat,
    input  wire logic                   i_spd_sat
);
    typedef struct packed {
        logic [15:0] nom_cnt;
        logic        spd;
        logic        bemf;
        logic        nom;
        logic        initial_position_detection;
        logic        csat;
        logic        ssat;
    } mlf_det_state_type;

    mlf_det_state_type s_q, s_d;
    logic [47:0]       spd_lhs, spd_rhs, bemf_lhs, bemf_rhs, nom_lhs, nom_rhs;
    logic              spd_hit, bemf_hit, nom_hit;
    logic              en1, en2, en3;

    assign en1 = cfg.fs2[mlf_pkg::L1_EN_BIT];
    assign en2 = cfg.fs2[mlf_pkg::L2_EN_BIT];
    assign en3 = cfg.fs2[mlf_pkg::L3_EN_BIT];

    // threshold compares scaled by 1000 so no divider is needed
    always_comb begin
        spd_lhs  = 48'(i_speed) * mlf_pkg::PM_SCALE;
        spd_rhs  = 48'(cfg.max_spd) *
                   mlf_pkg::mlf_spd_pm(cfg.fs2[mlf_pkg::SPD_LSB +: 3]);
        bemf_lhs = 48'(i_bemf) * mlf_pkg::PM_SCALE;
        bemf_rhs = 48'(32'(cfg.kconst) * 32'(i_speed)) *
                   mlf_pkg::mlf_bemf_pm(cfg.fs2[mlf_pkg::BEMF_LSB +: 3]);
        nom_lhs  = 48'(i_current) * mlf_pkg::PM_SCALE;
        nom_rhs  = 48'(cfg.base_cur) *
                   mlf_pkg::mlf_nom_pm(cfg.fs2[mlf_pkg::NOMTR_LSB +: 3]);
        spd_hit  = spd_lhs > spd_rhs;
        bemf_hit = bemf_lhs < bemf_rhs;
        nom_hit  = nom_lhs < nom_rhs;
    end

    // detectors; a disabled one is held clear with its filter reset
    always_comb begin
        s_d      = s_q;
        s_d.spd  = en1 && spd_hit;
        s_d.bemf = en2 && bemf_hit;
        if (!(en3 && nom_hit)) begin
            s_d.nom_cnt = 16'h0000;
        end else if (s_q.nom_cnt != 16'(NOMTR_CYC)) begin
            s_d.nom_cnt = s_q.nom_cnt + 16'h0001;
        end
        s_d.nom  = en3 && nom_hit && (s_q.nom_cnt == 16'(NOMTR_CYC));
        s_d.initial_position_detection  = cfg.fs2[mlf_pkg::IPD_EN_BIT] && i_ipd_freq_err;
        s_d.csat = cfg.fs2[mlf_pkg::SAT_EN_BIT] && i_cur_sat;
        s_d.ssat = cfg.fs2[mlf_pkg::SAT_EN_BIT] && i_spd_sat;
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign cfg.f_spd     = s_q.spd;
    assign cfg.f_bemf    = s_q.bemf;
    assign cfg.f_nom     = s_q.nom;
    assign cfg.f_ipd     = s_q.initial_position_detection;
    assign cfg.f_cur_sat = s_q.csat;
    assign cfg.f_spd_sat = s_q.ssat;

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_nrst);

    a_ipd_gated: assert property (
        ##1 cfg.f_ipd == $past(cfg.fs2[1] && i_ipd_freq_err))
        else $error("ipd fault not gated by its enable");
    a_sat_gated: assert property (
        !$past(cfg.fs2[0]) |-> !cfg.f_cur_sat && !cfg.f_spd_sat)
        else $error("saturation shown while disabled");
    a_spd_detect: assert property (
        en1 && spd_hit |=> cfg.f_spd)
        else $error("abnormal speed missed");
    a_bemf_off: assert property (
        !en2 |=> !cfg.f_bemf)
        else $error("back-emf detector ran while off");
    a_nom_off: assert property (
        !en3 |=> !cfg.f_nom ##1 !cfg.f_nom)
        else $error("no-motor flag while off");
    a_nom_filter: assert property (
        $rose(cfg.f_nom) |-> $past(nom_hit) && $past(en3))
        else $error("no-motor flag without low current");
    a_bemf_ref: assert property (
        en2 |=> cfg.f_bemf == $past(bemf_lhs < bemf_rhs))
        else $error("back-emf reference compare wrong");
    c_nom_seen: cover property ($rose(cfg.f_nom));
    c_spd_seen: cover property ($rose(cfg.f_spd));
endmodule // mlf_det

// ### core/mlf_top.sv
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/1ps
// How it works
// - the initial position frequency fault is raised only while bit 1 is set.
// - loop saturation is indicated only while bit 0 is set.
// - the abnormal speed detector runs only while bit 30 is one.
// - the abnormal back-emf detector runs only while bit 29 is one.
// - the no-motor detector runs only while bit 28 is one.
// - bits 27:25 pick a speed threshold of 130 to 200 percent of max speed.
// - bits 24:22 pick a back-emf threshold from 40 to 70 percent of expected.
// - expected back-emf is the back-emf constant times the estimated speed.
// - bits 21:19 pick a no-motor current threshold of 1 to 20 percent of base.
// - latched modes latch the fault, drive nfault low, tristate or brake.
// - retry modes clear after the retry time and latch past the retry limit.
module mlf_top #(
    parameter int CYC_PER_MS = mlf_pkg::CYC_PER_MS,
    parameter int NOMTR_CYC  = mlf_pkg::NOMTR_CYCLES
) (
    input  wire logic                   i_clk_sys,
    input  wire logic                   i_nrst,
    input  wire logic                   i_wb_cyc,
    input  wire logic                   i_wb_stb,
    input  wire logic                   i_wb_we,
    input  wire logic [11:0]            i_wb_adr,
    input  wire logic [31:0]            i_wb_dat,
    input  wire logic [3:0]             i_wb_sel,
    output logic      [31:0]            o_wb_dat,
    output logic                        o_wb_ack,
    input  wire logic [mlf_pkg::DW-1:0] i_speed,
    input  wire logic [mlf_pkg::DW-1:0] i_bemf,
    input  wire logic [mlf_pkg::DW-1:0] i_current,
    input  wire logic                   i_ipd_freq_err,
    input  wire logic                   i_cur_sat,
    input  wire logic                   i_spd_sat,
    output logic                        o_ipd_freq_fault,
    output logic                        o_cur_loop_sat,
    output logic                        o_spd_loop_sat,
    output logic                        o_nfault,
    output logic                        o_gate_tristate,
    output logic                        o_brake_low_side,
    output logic                        o_irq
);
    typedef struct packed {
        logic                 ack;
        logic [31:0]          rdat;
        logic [31:0]          fs2;
        logic [31:0]          lctl;
        logic [31:0]          kbase;
        logic [15:0]          maxspd;
        logic [5:0]           sts;
        logic [5:0]           msk;
        mlf_pkg::mlf_lock_type st;
        logic [31:0]          tmr;
        logic [2:0]           rcnt;
        logic                 nfault;
        logic                 tri_on;
        logic                 brake;
    } mlf_top_state_type;

    mlf_top_state_type s_q, s_d;
    mlf_det_if         dif ();

    logic        req, wr, rd, lock_ev, fclr;
    logic [3:0]  mode;
    logic [5:0]  ev;
    logic [31:0] retry_cyc;
    logic [31:0] mspd_m, msk_m;

    // byte-lane merge used by every writable register
    function automatic logic [31:0] wmerge(input logic [31:0] old,
                                           input logic [31:0] nw,
                                           input logic [3:0]  sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
        return a[11:2] == o[11:2];
    endfunction

    mlf_det #(
        .NOMTR_CYC (NOMTR_CYC)
    ) u_det (
        .i_clk_sys      (i_clk_sys),
        .i_nrst         (i_nrst),
        .cfg            (dif.det),
        .i_speed        (i_speed),
        .i_bemf         (i_bemf),
        .i_current      (i_current),
        .i_ipd_freq_err (i_ipd_freq_err),
        .i_cur_sat      (i_cur_sat),
        .i_spd_sat      (i_spd_sat)
    );

    assign dif.fs2      = s_q.fs2;
    assign dif.kconst   = s_q.kbase[15:0];
    assign dif.base_cur = s_q.kbase[31:16];
    assign dif.max_spd  = s_q.maxspd;

    // bus strobes and decoded control
    always_comb begin
        req       = i_wb_cyc && i_wb_stb && !s_q.ack;
        wr        = req && i_wb_we;
        rd        = req && !i_wb_we;
        mode      = s_q.lctl[mlf_pkg::MODE_LSB +: 4];
        fclr      = wr && hit(i_wb_adr, mlf_pkg::ADR_LCTL) &&
                    i_wb_sel[2] && i_wb_dat[mlf_pkg::FCLR_BIT];
        lock_ev   = dif.f_spd || dif.f_bemf || dif.f_nom;
        retry_cyc = mlf_pkg::mlf_retry_ms(s_q.lctl[mlf_pkg::RETRY_LSB +: 4]) *
                    32'(CYC_PER_MS);
        // merged words for the narrow registers, cut down where stored
        mspd_m    = wmerge({16'h0000, s_q.maxspd}, i_wb_dat, i_wb_sel);
        msk_m     = wmerge(32'(s_q.msk), i_wb_dat, i_wb_sel);
        ev        = '0;
        ev[mlf_pkg::ST_SPD]  = dif.f_spd;
        ev[mlf_pkg::ST_BEMF] = dif.f_bemf;
        ev[mlf_pkg::ST_NOM]  = dif.f_nom;
        ev[mlf_pkg::ST_IPD]  = dif.f_ipd;
        ev[mlf_pkg::ST_SAT]  = dif.f_cur_sat || dif.f_spd_sat;
        ev[mlf_pkg::ST_LOCK] = lock_ev && s_q.st == mlf_pkg::MLF_IDLE &&
                               mode < 4'h9;
    end

    // register file, status and lock response in one next-state process
    always_comb begin
        s_d      = s_q;
        s_d.ack  = req;
        s_d.rdat = 32'h00000000;
        if (rd) begin
            case (1'b1)
                hit(i_wb_adr, mlf_pkg::ADR_FS2):    s_d.rdat = s_q.fs2;
                hit(i_wb_adr, mlf_pkg::ADR_LCTL):   s_d.rdat = {16'h0000,
                                                    s_q.lctl[15:0]};
                hit(i_wb_adr, mlf_pkg::ADR_KBASE):  s_d.rdat = s_q.kbase;
                hit(i_wb_adr, mlf_pkg::ADR_MAXSPD): s_d.rdat = {16'h0000,
                                                    s_q.maxspd};
                hit(i_wb_adr, mlf_pkg::ADR_STS):    s_d.rdat = 32'(s_q.sts);
                hit(i_wb_adr, mlf_pkg::ADR_MSK):    s_d.rdat = 32'(s_q.msk);
                hit(i_wb_adr, mlf_pkg::ADR_STATE):  s_d.rdat = 32'({s_q.st,
                                                    s_q.rcnt, s_q.brake,
                                                    s_q.tri_on, !s_q.nfault});
                default:                            s_d.rdat = 32'h00000000;
            endcase
        end
        if (wr) begin
            if (hit(i_wb_adr, mlf_pkg::ADR_FS2)) begin
                s_d.fs2 = wmerge(s_q.fs2, i_wb_dat, i_wb_sel);
            end
            if (hit(i_wb_adr, mlf_pkg::ADR_LCTL)) begin
                s_d.lctl = wmerge(s_q.lctl, i_wb_dat, i_wb_sel) &
                           32'h000007FF;
            end
            if (hit(i_wb_adr, mlf_pkg::ADR_KBASE)) begin
                s_d.kbase = wmerge(s_q.kbase, i_wb_dat, i_wb_sel);
            end
            if (hit(i_wb_adr, mlf_pkg::ADR_MAXSPD)) begin
                s_d.maxspd = mspd_m[15:0];
            end
            if (hit(i_wb_adr, mlf_pkg::ADR_MSK)) begin
                s_d.msk = msk_m[5:0];
            end
        end
        // read clears status, but a new event in the same cycle survives
        if (rd && hit(i_wb_adr, mlf_pkg::ADR_STS)) begin
            s_d.sts = ev;
        end else begin
            s_d.sts = s_q.sts | ev;
        end
        // lock response
        if (s_q.tmr != 32'h00000000) begin
            s_d.tmr = s_q.tmr - 32'h00000001;
        end
        case (s_q.st)
            mlf_pkg::MLF_IDLE: begin
                s_d.nfault = 1'b1;
                s_d.tri_on = 1'b0;
                s_d.brake  = 1'b0;
                if (lock_ev && mode < 4'h9) begin
                    s_d.nfault = 1'b0;
                    s_d.tri_on = mode < 4'h8 && !mode[1];
                    s_d.brake  = mode < 4'h8 && mode[1];
                    if (mode == 4'h8) begin
                        s_d.st = mlf_pkg::MLF_REPORT;
                    end else if (mode < 4'h4 ||
                        s_q.rcnt >= s_q.lctl[mlf_pkg::RLIM_LSB +: 3]) begin
                        s_d.st = mlf_pkg::MLF_LATCHED;
                    end else begin
                        s_d.st  = mlf_pkg::MLF_RETRY;
                        s_d.tmr = retry_cyc;
                    end
                end
            end
            mlf_pkg::MLF_RETRY: begin
                if (s_q.tmr == 32'h00000001 || s_q.tmr == 32'h00000000) begin
                    s_d.st   = mlf_pkg::MLF_IDLE;
                    s_d.rcnt = s_q.rcnt + 3'h1;
                    s_d.tmr  = 32'h00000000;
                end
            end
            mlf_pkg::MLF_REPORT: begin
                if (!lock_ev) begin
                    s_d.st = mlf_pkg::MLF_IDLE;
                end
            end
            mlf_pkg::MLF_LATCHED: begin
                s_d.st = mlf_pkg::MLF_LATCHED;
            end
            default: s_d.st = mlf_pkg::MLF_IDLE;
        endcase
        // software clear releases a latched or retrying fault
        if (fclr) begin
            s_d.st     = mlf_pkg::MLF_IDLE;
            s_d.rcnt   = 3'h0;
            s_d.tmr    = 32'h00000000;
            s_d.nfault = 1'b1;
            s_d.tri_on = 1'b0;
            s_d.brake  = 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            s_q        <= '0;
            s_q.fs2    <= mlf_pkg::FS2_RST;
            s_q.st     <= mlf_pkg::MLF_IDLE;
            s_q.nfault <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_wb_dat         = s_q.rdat;
    assign o_wb_ack         = s_q.ack;
    assign o_ipd_freq_fault = dif.f_ipd;
    assign o_cur_loop_sat   = dif.f_cur_sat;
    assign o_spd_loop_sat   = dif.f_spd_sat;
    assign o_nfault         = s_q.nfault;
    assign o_gate_tristate  = s_q.tri_on;
    assign o_brake_low_side = s_q.brake;
    assign o_irq            = |(s_q.sts & s_q.msk);

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_nrst);

    a_ack_single: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("ack held more than one cycle");
    a_ack_follows: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack
        |=> o_wb_ack)
        else $error("request not answered next cycle");
    a_latch_mode: assert property (s_q.st == mlf_pkg::MLF_IDLE && lock_ev
        && mode < 4'h4 && !fclr |=> !o_nfault && o_gate_tristate
        != o_brake_low_side && s_q.st == mlf_pkg::MLF_LATCHED)
        else $error("latched lock response wrong");
    a_latch_holds: assert property (s_q.st == mlf_pkg::MLF_LATCHED && !fclr
        |=> s_q.st == mlf_pkg::MLF_LATCHED && !o_nfault)
        else $error("latched fault released without clear");
    a_retry_expiry: assert property (s_q.st == mlf_pkg::MLF_RETRY &&
        s_q.tmr == 32'h00000001 && !fclr |=> s_q.st == mlf_pkg::MLF_IDLE
        ##1 o_nfault || !$past(lock_ev))
        else $error("retry did not clear fault");
    a_retry_limit: assert property (s_q.st == mlf_pkg::MLF_IDLE && lock_ev
        && mode inside {[4'h4:4'h7]} && !fclr &&
        s_q.rcnt >= s_q.lctl[10:8] |=> s_q.st == mlf_pkg::MLF_LATCHED)
        else $error("retry limit not enforced");
    a_irq_level: assert property (o_irq |-> s_q.msk != 6'h00)
        else $error("irq mismatch");
    a_ipd_status: assert property (dif.f_ipd |=> s_q.sts[mlf_pkg::ST_IPD])
        else $error("ipd event lost");
    c_latched: cover property (s_q.st == mlf_pkg::MLF_LATCHED);
    c_retry_done: cover property (s_q.st == mlf_pkg::MLF_RETRY
        ##1 s_q.st == mlf_pkg::MLF_IDLE);
    c_irq: cover property ($rose(o_irq));
endmodule // mlf_top

// ### dv/mlf_top_tb.sv
`timescale 1ns/1ps
module mlf_top_tb;
    logic        clk  = 1'h0;
    logic        nrst = 1'h0;
    logic        req  = 1'h0;
    logic        we   = 1'h0;
    logic [11:0] adr  = 12'h000;
    logic [31:0] wdat = 32'h0;
    logic [15:0] spd  = 16'h0;
    logic [15:0] bemf = 16'h0;
    logic [15:0] cur  = 16'h0;
    logic [2:0]  raw  = 3'h0;
    logic [31:0] rdat;
    logic [31:0] rd;
    logic        ack, ipd_f, csat, ssat, nflt, tri_o, brk, irq;
    int          mismatches = 0;
    int          cmp_count  = 0;
    // bemf codes: largest tripping value at expected 100; no-motor per-mille
    logic [15:0] bf [8] = '{16'h27, 16'h2C, 16'h31, 16'h36,
                            16'h3B, 16'h40, 16'h43, 16'h45};
    logic [15:0] np [8] = '{16'h0A, 16'h14, 16'h1E, 16'h28,
                            16'h32, 16'h4B, 16'h64, 16'hC8};

    // short counts keep the retry timer and no-motor filter quick
    mlf_top #(.CYC_PER_MS(2), .NOMTR_CYC(4)) uut (
        .i_clk_sys(clk), .i_nrst(nrst), .i_wb_cyc(req), .i_wb_stb(req),
        .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(4'hF),
        .o_wb_dat(rdat), .o_wb_ack(ack), .i_speed(spd), .i_bemf(bemf),
        .i_current(cur), .i_ipd_freq_err(raw[2]), .i_cur_sat(raw[1]),
        .i_spd_sat(raw[0]), .o_ipd_freq_fault(ipd_f),
        .o_cur_loop_sat(csat), .o_spd_loop_sat(ssat), .o_nfault(nflt),
        .o_gate_tristate(tri_o), .o_brake_low_side(brk), .o_irq(irq));

    // 50 ns period
    initial begin
        forever #25 clk = ~clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    // classic cycle; bounded wait so a silent slave still ends the run
    task automatic bus(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge clk);
        req <= 1'h1;
        we <= w;
        adr <= a;
        wdat <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'h1 && n < 50);
        rd = rdat;
        req <= 1'h0;
        if (n >= 50) begin
            mismatches++;
            end_sim();
        end
    endtask

    // first status read drops history, second shows live flags
    task automatic probe(input logic [15:0] s, input logic [15:0] b,
                         input logic [15:0] c, input logic [2:0] e);
        spd <= s;
        bemf <= b;
        cur <= c;
        tick(10);
        bus(1'h0, mlf_pkg::ADR_STS, 32'h0);
        tick(2);
        bus(1'h0, mlf_pkg::ADR_STS, 32'h0);
        chk({29'h0, rd[2:0]}, {29'h0, e});
    endtask

    initial begin
        tick(12);
        nrst <= 1'h1;
        bus(1'h0, mlf_pkg::ADR_FS2, 32'h0);
        chk(rd, mlf_pkg::FS2_RST);
        bus(1'h0, 12'h800, 32'h0);
        chk(rd, 32'h0);
        bus(1'h1, mlf_pkg::ADR_FS2, 32'hFFFFFFFF);
        bus(1'h0, mlf_pkg::ADR_FS2, 32'h0);
        chk(rd, 32'hFFFFFFFF);
        // raw events pass only once their enables are set
        bus(1'h1, mlf_pkg::ADR_FS2, 32'h0);
        raw <= 3'h7;
        tick(3);
        chk({29'h0, ipd_f, csat, ssat}, 32'h0);
        bus(1'h1, mlf_pkg::ADR_FS2, 32'h3);
        tick(3);
        chk({29'h0, ipd_f, csat, ssat}, 32'h7);
        raw <= 3'h0;
        bus(1'h1, mlf_pkg::ADR_KBASE, 32'h03E80001);
        bus(1'h1, mlf_pkg::ADR_MAXSPD, 32'h00000064);
        probe(16'hC8, 16'h0, 16'h0, 3'h0);
        // irq follows unmasked status, read clears it
        bus(1'h1, mlf_pkg::ADR_MSK, 32'h1);
        bus(1'h1, mlf_pkg::ADR_FS2, 32'h40000000);
        spd <= 16'hC8;
        tick(4);
        chk({31'h0, irq}, 32'h1);
        spd <= 16'h64;
        tick(2);
        bus(1'h0, mlf_pkg::ADR_STS, 32'h0);
        tick(2);
        chk({31'h0, irq}, 32'h0);
        bus(1'h1, mlf_pkg::ADR_MSK, 32'h0);
        spd <= 16'hC8;
        tick(4);
        chk({31'h0, irq}, 32'h0);
        // every threshold code, one step each side of its boundary
        for (int c = 0; c < 8; c++) begin
            bus(1'h1, mlf_pkg::ADR_FS2,
                {1'h0, 3'h7, 3'(c), 3'(c), 3'(c), 19'h0});
            probe(16'(c) * 16'hA + 16'h83, 16'hFFFF, 16'hFFFF, 3'h1);
            probe(16'(c) * 16'hA + 16'h82, 16'hFFFF, 16'hFFFF, 3'h0);
            probe(16'h64, bf[c], np[c] - 16'h1, 3'h6);
            probe(16'h64, bf[c] + 16'h1, np[c], 3'h0);
        end
        // lock taken earlier in mode 0 stays latched and tristated
        chk({29'h0, nflt, tri_o, brk}, 32'h2);
        bus(1'h1, mlf_pkg::ADR_LCTL, 32'h00010002);
        tick(2);
        chk({29'h0, nflt, tri_o, brk}, 32'h4);
        spd <= 16'hFFFF;
        tick(4);
        chk({29'h0, nflt, tri_o, brk}, 32'h1);
        // retry mode, 300 ms at 2 cycles per ms, one retry allowed
        spd <= 16'h64;
        bus(1'h1, mlf_pkg::ADR_LCTL, 32'h00010104);
        spd <= 16'hFFFF;
        tick(500);
        chk({29'h0, nflt, tri_o, brk}, 32'h2);
        spd <= 16'h64;
        tick(150);
        chk({29'h0, nflt, tri_o, brk}, 32'h4);
        spd <= 16'hFFFF;
        tick(4);
        bus(1'h0, mlf_pkg::ADR_STATE, 32'h0);
        chk({24'h0, rd[7:0]}, 32'h4B);
        end_sim();
    end
endmodule // mlf_top_tb
